//--- rcp_pkg.sv
// Constants, types and register map of the reset-cause and power control block.
// Assumes a single 10 MHz clock and a 32-bit classic Wishbone register bus.
package rcp_pkg;

   // =====================================================
   // Register indices (byte address is four times index)
   // =====================================================
   localparam logic [9:0] RCP_IDX_PWR_STATUS = 10'h08E;
   localparam logic [9:0] RCP_IDX_IRQ_STATUS = 10'h090;
   localparam logic [9:0] RCP_IDX_IRQ_MASK   = 10'h091;
   localparam logic [9:0] RCP_IDX_CONFIG     = 10'h092;
   localparam logic [9:0] RCP_IDX_CAUSE      = 10'h093;

   // =====================================================
   // Field positions
   // =====================================================
   localparam int RCP_BIT_BRN_FLAG  = 0;
   localparam int RCP_BIT_POR_FLAG  = 1;
   localparam int RCP_BIT_OSC_SPEED = 3;
   localparam int RCP_BIT_BRN_EN    = 0;
   localparam logic [7:0] RCP_PWR_IMPL_MASK = 8'h0B;

   // =====================================================
   // Reset values
   // =====================================================
   localparam logic       RCP_RST_OSC_SPEED = 1'b1;
   localparam logic       RCP_RST_POR_FLAG  = 1'b0;
   localparam logic       RCP_RST_BRN_FLAG  = 1'b0;
   localparam logic       RCP_RST_BRN_EN    = 1'b1;
   localparam logic [3:0] RCP_RST_IRQ_MASK  = 4'h0;

   // =====================================================
   // Types
   // =====================================================
   // One-cycle reset-cause pulses, one bit per source
   typedef struct packed {
      logic watchdog_timer;
      logic external_reset_pin;
      logic power_on;
      logic brownout;
   } rcp_events_t;

   typedef enum logic [2:0] {
      RCP_CAUSE_NONE     = 3'h0,
      RCP_CAUSE_POWER_ON = 3'h1,
      RCP_CAUSE_BROWNOUT = 3'h2,
      RCP_CAUSE_EXT_PIN  = 3'h3,
      RCP_CAUSE_WATCHDOG = 3'h4
   } rcp_cause_t;

   typedef enum logic [0:0] {
      RCP_BUS_IDLE = 1'b0,
      RCP_BUS_ACK  = 1'b1
   } rcp_bus_state_t;

endpackage

//--- rcp_reset_cause.sv
// Reset-cause flags, oscillator speed select and event interrupt behind Wishbone.
// Holds the status word software reads after any reset, a last-cause record,
// a brown-out detect enable and a sticky event register with its mask.
// Assumes reset-cause pulses arrive synchronous to clk_i, one cycle long.
// Assumes rst_i is the power-on reset of this block and that the core
// keeps the Wishbone master in reset while rst_i is high.
`timescale 1ns/1ps

module rcp_reset_cause #(
   parameter int ADR_W = 12
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone slave
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [ADR_W-1:0]     adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   // Reset-cause pulses
   input  wire rcp_pkg::rcp_events_t events_i,
   // Oscillator, detector enable and interrupt
   output logic                      osc_speed_select_o,
   output logic                      brownout_detect_enable_o,
   output logic                      irq_o
);
   import rcp_pkg::*;

   // =====================================================
   // Storage
   // =====================================================
   // Bus side
   rcp_bus_state_t bus_state;

   // Status word fields and the detect enable
   logic           por_flag;
   logic           brownout_flag;
   logic           osc_speed;
   logic           brn_enable;

   // Event register, mask and cause record
   logic [3:0]     irq_status;
   logic [3:0]     next_irq_status;
   logic [3:0]     irq_mask;
   rcp_cause_t     last_cause;

   // Decode helpers
   logic [9:0]     word_idx;
   logic           req;
   logic           wr_low;
   logic           rd_take;
   logic           brn_hit;
   logic [3:0]     ev_vec;
   logic           any_event;
   logic [31:0]    next_dat;

   // Write strobes of the three writable registers, the event-register read strobe and the pending request
   logic           pwr_wr;
   logic           cfg_wr;
   logic           mask_wr;
   logic           irq_rd;
   logic           irq_pending;

   // =====================================================
   // Request decode
   // =====================================================
   // Byte address to word index; the two low bits select no register
   function automatic logic [9:0] to_index(input logic [ADR_W-1:0] a);
      logic [ADR_W-1:0] s;
      s = a >> 2;
      return s[9:0];
   endfunction

   // A taken request of the given kind that addresses one word index
   function automatic logic reg_hit(input logic       strobe,
                                    input logic [9:0] idx,
                                    input logic [9:0] want);
      return strobe && (idx == want);
   endfunction

   // Highest-priority cause among the pulses of one cycle
   // Power-on first, then brown-out, watchdog and the external pin
   function automatic rcp_cause_t cause_of(input logic [3:0] ev);
      rcp_cause_t c;
      c = RCP_CAUSE_NONE;
      if (ev[1]) begin
         c = RCP_CAUSE_POWER_ON;
      end else if (ev[0]) begin
         c = RCP_CAUSE_BROWNOUT;
      end else if (ev[3]) begin
         c = RCP_CAUSE_WATCHDOG;
      end else if (ev[2]) begin
         c = RCP_CAUSE_EXT_PIN;
      end
      return c;
   endfunction

   // Only ten index bits exist; wider buses alias the map upward
   assign word_idx = to_index(adr_i);
   assign req      = cyc_i && stb_i && (bus_state == RCP_BUS_IDLE);
   assign wr_low   = req && we_i && sel_i[0];
   // Reads with any byte lane select return the whole word
   assign rd_take  = req && !we_i;

   // Gated by detect enable
   // A disabled detector may still pulse; such a pulse neither clears the
   // flag nor counts as a reset of the core.
   assign brn_hit  = events_i.brownout && brn_enable;
   assign ev_vec   = {events_i.watchdog_timer, events_i.external_reset_pin,
                      events_i.power_on, brn_hit};

   // Every source that counts as a reset of the core, after gating
   assign any_event = |ev_vec;

   // =====================================================
   // Register strobes
   // =====================================================
   // Writes only touch byte lane 0; the upper lanes carry no field, so a
   // write with sel_i[0] low leaves every register as it was.
   assign pwr_wr  = reg_hit(wr_low, word_idx, RCP_IDX_PWR_STATUS);
   assign cfg_wr  = reg_hit(wr_low, word_idx, RCP_IDX_CONFIG);
   assign mask_wr = reg_hit(wr_low, word_idx, RCP_IDX_IRQ_MASK);
   // Reads of the event register clear it; reads elsewhere have no side effect
   assign irq_rd  = reg_hit(rd_take, word_idx, RCP_IDX_IRQ_STATUS);

   // =====================================================
   // Bus handshake
   // =====================================================
   // One wait state: ack one cycle after the request, then idle again.
   // The ack cycle ignores cyc and stb, so a master that drops stb on the edge
   // that samples ack is not answered twice for the same request.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state <= RCP_BUS_IDLE;
         ack_o     <= 1'b0;
      end else begin
         unique case (bus_state)
            RCP_BUS_IDLE: begin
               // Any request is answered, mapped or not
               if (cyc_i && stb_i) begin
                  bus_state <= RCP_BUS_ACK;
                  ack_o     <= 1'b1;
               end
            end
            RCP_BUS_ACK: begin
               // Back to idle whatever the master does
               bus_state <= RCP_BUS_IDLE;
               ack_o     <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================
   // Read data
   // =====================================================
   // Unmapped indices and unused bits read as zero
   always_comb begin
      next_dat = 32'h0000_0000;
      unique case (word_idx)
         RCP_IDX_PWR_STATUS: begin
            next_dat[RCP_BIT_OSC_SPEED] = osc_speed;
            next_dat[RCP_BIT_POR_FLAG]  = por_flag;
            next_dat[RCP_BIT_BRN_FLAG]  = brownout_flag;
         end
         // Words beyond the status register belong to this block alone
         RCP_IDX_IRQ_STATUS: next_dat[3:0] = irq_status;
         RCP_IDX_IRQ_MASK:   next_dat[3:0] = irq_mask;
         RCP_IDX_CONFIG:     next_dat[RCP_BIT_BRN_EN] = brn_enable;
         RCP_IDX_CAUSE:      next_dat[2:0] = last_cause;
         default:            next_dat = 32'h0000_0000;
      endcase
   end

   // Read data is registered with ack and forced to zero outside it, so
   // nothing leaks onto a shared return bus between transfers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd_take) begin
         dat_o <= next_dat;
      end else begin
         // Zero outside the ack cycle
         dat_o <= 32'h0000_0000;
      end
   end

   // =====================================================
   // Power-on flag
   // =====================================================
   // Cleared by hardware, set only by software. A power-on pulse wins over
   // a write in the same cycle, so a cause is never lost to a racing write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         por_flag <= RCP_RST_POR_FLAG;
      end else if (events_i.power_on) begin
         por_flag <= 1'b0;
      end else if (pwr_wr) begin
         por_flag <= dat_i[RCP_BIT_POR_FLAG];
      end
   end

   // =====================================================
   // Brown-out flag
   // =====================================================
   // The value after power-on carries no meaning; zero is kept so that
   // simulation starts from a known state. Software must write it to one.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         brownout_flag <= RCP_RST_BRN_FLAG;
      end else if (brn_hit) begin
         brownout_flag <= 1'b0;
      end else if (events_i.power_on) begin
         brownout_flag <= RCP_RST_BRN_FLAG;
      end else if (pwr_wr) begin
         brownout_flag <= dat_i[RCP_BIT_BRN_FLAG];
      end
   end

   // =====================================================
   // Oscillator speed select
   // =====================================================
   // Any reset of the core returns the oscillator to the fast setting; the
   // output stage adds one cycle so the clock switch sees a clean level.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_speed <= RCP_RST_OSC_SPEED;
      end else if (any_event) begin
         osc_speed <= RCP_RST_OSC_SPEED;
      end else if (pwr_wr) begin
         osc_speed <= dat_i[RCP_BIT_OSC_SPEED];
      end
   end

   // Registered copy for the clock switch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_speed_select_o <= RCP_RST_OSC_SPEED;
      end else begin
         osc_speed_select_o <= osc_speed;
      end
   end

   // =====================================================
   // Configuration
   // =====================================================
   // Stands in for the configuration word bit; writable here so that both
   // settings of the detector can be exercised.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         brn_enable <= RCP_RST_BRN_EN;
      end else if (cfg_wr) begin
         brn_enable <= dat_i[RCP_BIT_BRN_EN];
      end
   end

   // Registered copy for the detector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         brownout_detect_enable_o <= RCP_RST_BRN_EN;
      end else begin
         brownout_detect_enable_o <= brn_enable;
      end
   end

   // =====================================================
   // Last reset cause
   // =====================================================
   // Records the highest-priority source of the most recent reset; kept
   // apart from the status flags, which software may rewrite freely.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_cause <= RCP_CAUSE_POWER_ON;
      end else if (any_event) begin
         last_cause <= cause_of(ev_vec);
      end
   end

   // =====================================================
   // Event interrupt
   // =====================================================
   // Read clears; an event in the same cycle is kept.
   // A read races the event only by one edge, so the set must win or the
   // event would vanish unseen.
   always_comb begin
      if (irq_rd) begin
         next_irq_status = ev_vec;
      end else begin
         next_irq_status = irq_status | ev_vec;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= 4'h0;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   // Mask bits follow the event register layout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= RCP_RST_IRQ_MASK;
      end else if (mask_wr) begin
         irq_mask <= dat_i[3:0];
      end
   end

   // Level request while any unmasked event is pending
   assign irq_pending = |(irq_status & irq_mask);

   // Level output, one cycle behind the pending bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_pending;
      end
   end

endmodule

//--- rcp_reset_cause_assertions.sv
// Port-level checker of the reset-cause block.
// Assumes it is bound onto rcp_reset_cause.
`timescale 1ns/1ps
module rcp_reset_cause_assertions #(
   parameter int ADR_W = 12
) (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 cyc_i,
   input wire logic                 stb_i,
   input wire logic                 we_i,
   input wire logic [ADR_W-1:0]     adr_i,
   input wire logic [3:0]           sel_i,
   input wire logic [31:0]          dat_i,
   input wire logic [31:0]          dat_o,
   input wire logic                 ack_o,
   input wire rcp_pkg::rcp_events_t events_i,
   input wire logic                 osc_speed_select_o,
   input wire logic                 brownout_detect_enable_o,
   input wire logic                 irq_o
);
   import rcp_pkg::*;
   // ==========================================
   // Assertions
   // ==========================================
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_timing_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered in one cycle");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");
   dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   dat_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("upper read data not zero");
   status_unused_a: assert property (ack_o && !we_i && adr_i == 12'h238
      |-> dat_o[7:4] == 4'h0 && !dat_o[2]) else $error("unused status bit set");
   osc_rst_a: assert property (disable iff (1'b0) rst_i && $past(rst_i)
      |-> osc_speed_select_o) else $error("osc speed not fast in reset");
   osc_event_a: assert property ((events_i.watchdog_timer || events_i.external_reset_pin
      || events_i.power_on || (events_i.brownout && brownout_detect_enable_o))
      |-> ##2 osc_speed_select_o)
      else $error("osc speed not fast after reset event");
   irq_rise_a: assert property ($rose(irq_o)
      |-> $past(events_i != 4'h0, 2) || $past(ack_o && we_i)) else $error("irq without cause");
   irq_fall_a: assert property ($fell(irq_o) |-> $past(ack_o))
      else $error("irq dropped without access");
   bor_en_a: assert property ($changed(brownout_detect_enable_o)
      |-> $past(ack_o && we_i && adr_i == 12'h248)) else $error("enable changed alone");
   cover property (events_i.brownout ##2 irq_o);
   cover property (ack_o && !we_i && adr_i == 12'h238);
   cover property ($fell(irq_o));
endmodule

bind rcp_reset_cause rcp_reset_cause_assertions #(.ADR_W(ADR_W)) u_chk (.*);

//--- rcp_reset_cause_test.sv
// Self-checking bench of the reset-cause block over Wishbone.
// Assumes the checker file is compiled with the design.
`timescale 1ns/1ps
module rcp_reset_cause_test;
   import rcp_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, osc_o, en_o, irq_o;
   logic [11:0] adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, q;
   rcp_events_t events_i;
   int          n_mismatch, num_checks;
   rcp_reset_cause #(.ADR_W(12)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .events_i(events_i), .osc_speed_select_o(osc_o),
      .brownout_detect_enable_o(en_o), .irq_o(irq_o));
   // ==========================================
   // Tasks
   // ==========================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      check(q, {24'h0, e});
   endtask
   task automatic ev(input logic [3:0] e);
      @(posedge clk_i);
      events_i <= rcp_events_t'(e);
      @(posedge clk_i);
      events_i <= '0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================
   // Clock, watchdog and tests
   // ==========================================
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      #200000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      {rst_i, cyc_i, stb_i, we_i} = 4'h8;
      {adr_i, dat_i} = '0;
      sel_i = 4'hF;
      events_i = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(12'h238, 8'h08);
      check({31'h0, osc_o}, 32'h1);
      rd(12'h24C, 8'h01);
      rd(12'h248, 8'h01);
      wb(1'b1, 12'h238, 8'hFF);
      rd(12'h238, 8'h0B);
      wb(1'b1, 12'h244, 8'h01);
      ev(4'h1);
      rd(12'h238, 8'h0A);
      check({31'h0, irq_o}, 32'h1);
      rd(12'h24C, 8'h02);
      rd(12'h240, 8'h01);
      #1;
      check({31'h0, irq_o}, 32'h0);
      wb(1'b1, 12'h238, 8'hFF);
      for (int i = 2; i < 4; i++) begin
         ev(4'h1 << i);
         rd(12'h238, 8'h0B);
         rd(12'h24C, 8'(i + 1));
      end
      check({31'h0, irq_o}, 32'h0);
      ev(4'h2);
      rd(12'h238, 8'h08);
      rd(12'h24C, 8'h01);
      wb(1'b1, 12'h238, 8'h03);
      rd(12'h238, 8'h03);
      check({31'h0, osc_o}, 32'h0);
      ev(4'h4);
      check({31'h0, osc_o}, 32'h1);
      wb(1'b1, 12'h248, 8'h00);
      @(posedge clk_i);
      check({31'h0, en_o}, 32'h0);
      ev(4'h1);
      rd(12'h238, 8'h0B);
      check({31'h0, irq_o}, 32'h0);
      sel_i <= 4'hE;
      wb(1'b1, 12'h238, 8'h00);
      sel_i <= 4'hF;
      rd(12'h238, 8'h0B);
      wb(1'b1, 12'h000, 8'hFF);
      rd(12'h000, 8'h00);
      finish_test();
   end
endmodule
